// ==== src/phycfg_setup_reg.v ====
// Primary setup register of the single-pair PHY with its decoded controls
// Notes on behaviour
// - Bit 15 sets role: 0 slave, 1 master.
// - Role, self-governing bit and host interface field load from straps on the first clock after reset release.
// - Field 9:8: MII, RMII with 50 MHz reference, RMII from 25 MHz crystal, reverse MII.
// - Bit 7 picks driver strength: 0 standard (reset), 1 reduced.
// - Bit 6 set: partner confirmation required before sleep; reset 0.
// - Field 5:4 picks indicator source: link, receive (reset), symbol error, carrier sense.
// - Bit 3 set enables indicator, disables wake input; reset 0 the reverse.
// - Wake input accepted only in Sleep, Sleep Request, Standby with indicator off.
// - Bit 2 picks wake threshold: 0 absolute (reset), 1 supply-ratiometric.
// - Bit 0 set (reset) enables automatic Normal to Sleep Request on LPS.
// - Writes take effect only while configuration access enable is set.
`timescale 1ns/100ps
`include "phycfg_consts.vh"
module phycfg_setup_reg (
  // Clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // Strap pins, held steady around reset release
  input  wire        strapRole,
  input  wire        strapSelfGov,
  input  wire [1:0]  strapHostIf,
  // Register access from the management interface
  input  wire [4:0]  regAddr,
  input  wire        regWrite,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  input  wire        configAccessEn,
  // Power mode state indications
  input  wire        modeSleep,
  input  wire        modeSleepReq,
  input  wire        modeStandby,
  // Indicator sources and wake pad
  input  wire        linkUp,
  input  wire        frameReceivingFlag,
  input  wire        symbolError,
  input  wire        carrierSense,
  input  wire        wakePadIn,
  // Decoded controls
  output wire        roleMaster,
  output wire        selfGoverningOperation,
  output wire        cableLong,
  output wire [1:0]  txAmplitude,
  output wire [1:0]  hostIfMode,
  output wire        rmiiRefClkUsed,
  output wire        driveReduced,
  output wire        partnerDozeHandshake,
  output wire [1:0]  indicatorSourceSelect,
  output wire        indicatorPinEnable,
  output wire        wakeRatiometric,
  output wire        selfPowerDown,
  output wire        lowPowerSymbolDozeEntry,
  // Pad results
  output reg         indicatorOut,
  output reg         localWake
);


  // Widths of the stored word and of the indicator source set
  localparam integer REG_W = 16;
  localparam integer SRC_N = 4;

  // Strap-loaded fields read 0 in reset and fill on the first clock after release
  localparam [REG_W-1:0] RESET_IMAGE = {
    2'b00,
    1'b0,
    1'b0,
    `PHYCFG_RST_TXAMP,
    2'b00,
    1'b0,
    1'b0,
    `PHYCFG_RST_IND,
    1'b0,
    1'b0,
    1'b0,
    `PHYCFG_RST_LPSDOZE
  };

  // Same decode serves the write path and the read mux
  function addrHit;
    input [4:0] addr;
    begin
      addrHit = (addr == `PHYCFG_ADDR_SETUP);
    end
  endfunction

  reg  [REG_W-1:0] setup_q;
  reg  [REG_W-1:0] setup_d;
  reg  [REG_W-1:0] strapImage;
  reg              strapDone_q;
  wire             writeHit;
  wire             readHit;
  wire             writeTake;

  assign writeHit = addrHit(regAddr);
  assign readHit  = addrHit(regAddr);

  // A write on the strap capture edge is lost, never merged with the straps
  assign writeTake = regWrite & writeHit & configAccessEn & strapDone_q;

  // Straps laid over the current word
  always @*
  begin
    strapImage                                      = setup_q;
    strapImage[`PHYCFG_BIT_ROLE]                    = strapRole;
    strapImage[`PHYCFG_BIT_SELFGOV]                 = strapSelfGov;
    strapImage[`PHYCFG_HOSTIF_HI:`PHYCFG_HOSTIF_LO] = strapHostIf;
  end

  always @*
  begin
    setup_d = setup_q;
    if (!strapDone_q)
    begin
      // Straps caught on a clock, so the async branch stays constant
      setup_d = strapImage;
    end
    else if (writeTake)
    begin
      // Whole word taken; reserved bit kept as written
      setup_d = regWdata;
    end
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapDone_q <= 1'b0;
    end
    else
    begin
      strapDone_q <= 1'b1;
    end
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      setup_q <= RESET_IMAGE;
    end
    else
    begin
      setup_q <= setup_d;
    end
  end

  always @*
  begin
    if (readHit)
    begin
      regRdata = setup_q;
    end
    else
    begin
      regRdata = 16'h0000;
    end
  end

  assign roleMaster              = setup_q[`PHYCFG_BIT_ROLE];
  assign selfGoverningOperation  = setup_q[`PHYCFG_BIT_SELFGOV];
  assign cableLong               = setup_q[`PHYCFG_BIT_CABLE];
  assign txAmplitude             = setup_q[`PHYCFG_TXAMP_HI:`PHYCFG_TXAMP_LO];
  assign hostIfMode              = setup_q[`PHYCFG_HOSTIF_HI:`PHYCFG_HOSTIF_LO];
  assign rmiiRefClkUsed          = (hostIfMode == `PHYCFG_HOSTIF_RMII_REF);
  assign driveReduced            = setup_q[`PHYCFG_BIT_DRIVE];
  assign partnerDozeHandshake    = setup_q[`PHYCFG_BIT_DOZEHS];
  assign indicatorSourceSelect   = setup_q[`PHYCFG_IND_HI:`PHYCFG_IND_LO];
  assign indicatorPinEnable      = setup_q[`PHYCFG_BIT_INDEN];
  assign wakeRatiometric         = setup_q[`PHYCFG_BIT_WAKETHR];
  assign selfPowerDown           = setup_q[`PHYCFG_BIT_SELFPWD];
  assign lowPowerSymbolDozeEntry = setup_q[`PHYCFG_BIT_LPSDOZE];

  // Indicator source set in code order
  wire [SRC_N-1:0] srcVec;
  wire [SRC_N-1:0] srcOneHot;
  wire [SRC_N-1:0] srcGated;
  wire             wakeWindow;
  wire             indicatorOut_d;
  wire             localWake_d;

  assign srcVec    = {carrierSense, symbolError, frameReceivingFlag, linkUp};
  assign srcOneHot = 4'h1 << indicatorSourceSelect;

  genvar k;
  generate
    for (k = 0; k < SRC_N; k = k + 1)
    begin : gSrc
      assign srcGated[k] = srcOneHot[k] & srcVec[k];
    end
  endgenerate

  // Shared pin: indicator and wake input are never live together
  assign indicatorOut_d = indicatorPinEnable & (|srcGated);
  assign wakeWindow     = modeSleep | modeSleepReq | modeStandby;
  assign localWake_d    = wakePadIn & ~indicatorPinEnable & wakeWindow;

  // Registered pad outputs; one cycle of latency is harmless at pad speeds
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      indicatorOut <= 1'b0;
    end
    else
    begin
      indicatorOut <= indicatorOut_d;
    end
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      localWake <= 1'b0;
    end
    else
    begin
      localWake <= localWake_d;
    end
  end

endmodule // phycfg_setup_reg

// ==== inc/phycfg_consts.vh ====
// Offsets, field positions and reset values of the primary setup register
`ifndef PHYCFG_CONSTS_VH
`define PHYCFG_CONSTS_VH
`define PHYCFG_ADDR_SETUP        5'h12
`define PHYCFG_BIT_ROLE          15
`define PHYCFG_BIT_SELFGOV       14
`define PHYCFG_BIT_CABLE         13
`define PHYCFG_BIT_RSVD          12
`define PHYCFG_TXAMP_HI          11
`define PHYCFG_TXAMP_LO          10
`define PHYCFG_HOSTIF_HI         9
`define PHYCFG_HOSTIF_LO         8
`define PHYCFG_BIT_DRIVE         7
`define PHYCFG_BIT_DOZEHS        6
`define PHYCFG_IND_HI            5
`define PHYCFG_IND_LO            4
`define PHYCFG_BIT_INDEN         3
`define PHYCFG_BIT_WAKETHR       2
`define PHYCFG_BIT_SELFPWD       1
`define PHYCFG_BIT_LPSDOZE       0
`define PHYCFG_RST_TXAMP         2'h2
`define PHYCFG_RST_IND           2'h1
`define PHYCFG_RST_LPSDOZE       1'h1
`define PHYCFG_HOSTIF_MII        2'h0
`define PHYCFG_HOSTIF_RMII_REF   2'h1
`define PHYCFG_HOSTIF_RMII_XTAL  2'h2
`define PHYCFG_HOSTIF_REVMII     2'h3
`define PHYCFG_IND_LINK          2'h0
`define PHYCFG_IND_RECV          2'h1
`define PHYCFG_IND_SYMERR        2'h2
`define PHYCFG_IND_CRS           2'h3
`endif

// ==== verification/phycfg_host.sv ====
// Management controller model issuing register accesses
`timescale 1ns/100ps
module phycfg_host (
  input wire mclk,
  output logic [4:0] regAddr = 0,
  output logic regWrite = 0,
  output logic [15:0] regWdata = 0,
  output logic configAccessEn = 0
);
  task wr(input [4:0] a, input [15:0] d, input e);
    @(negedge mclk) {regAddr, regWdata, configAccessEn, regWrite} = {a, d, e, 1'b1};
    @(negedge mclk) regWrite = 0;
  endtask
  task rd(input [4:0] a);
    @(negedge mclk) regAddr = a;
  endtask
endmodule // phycfg_host

// ==== verification/phycfg_setup_assertions.sv ====
// Port checker of the primary setup register
`timescale 1ns/100ps
module phycfg_setup_chk (
  input wire mclk, arst_n, regWrite, configAccessEn, roleMaster, rmiiRefClkUsed, indicatorPinEnable,
  input wire lowPowerSymbolDozeEntry, indicatorOut, localWake, linkUp, frameReceivingFlag, symbolError,
  input wire carrierSense, wakePadIn, modeSleep, modeSleepReq, modeStandby,
  input wire [1:0] hostIfMode, indicatorSourceSelect,
  input wire [4:0] regAddr,
  input wire [15:0] regWdata, regRdata
);
  // Strap capture edge swallows writes
  reg live_q;
  wire take = live_q && regWrite && regAddr == 5'h12 && configAccessEn;
  wire [3:0] src = {carrierSense, symbolError, frameReceivingFlag, linkUp};
  wire wakeOk = wakePadIn & ~indicatorPinEnable & (modeSleep | modeSleepReq | modeStandby);
  always @(posedge mclk or negedge arst_n)
    if (!arst_n) live_q <= 1'b0;
    else live_q <= 1'b1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  write_take_a: assert property (take ##1 regAddr == 5'h12 |-> regRdata == $past(regWdata))
    else $error("write lost");
  write_refuse_a: assert property (live_q && !take |=> $stable({roleMaster, hostIfMode, indicatorPinEnable}))
    else $error("refused write landed");
  role_write_a: assert property (take |=> roleMaster == $past(regWdata[15]))
    else $error("role");
  reset_value_a: assert property (!live_q && regAddr == 5'h12 |-> (regRdata & 16'h3cff) == 16'h0811)
    else $error("reset value");
  rmii_ref_a: assert property (rmiiRefClkUsed == (hostIfMode == 2'h1))
    else $error("rmii ref");
  lps_map_a: assert property (regAddr == 5'h12 |-> lowPowerSymbolDozeEntry == regRdata[0])
    else $error("lps decode");
  indicator_pad_a: assert property (1'b1 |=> indicatorOut == $past(indicatorPinEnable & src[indicatorSourceSelect]))
    else $error("indicator");
  wake_gate_a: assert property (1'b1 |=> localWake == $past(wakeOk))
    else $error("wake");
  cover property (take);
  cover property (localWake);
  cover property (indicatorOut);
endmodule // phycfg_setup_chk
bind phycfg_setup_reg phycfg_setup_chk chk (.*);

// ==== verification/test_phy_primary_config_reg.sv ====
// Self-checking bench of the primary setup register
`timescale 1ns/100ps
module test_phy_primary_config_reg;
  logic mclk = 0, arst_n = 0, indicatorOut, localWake, en;
  logic [11:0] r = 0;
  logic [15:0] regRdata, d, x;
  logic [4:0] a;
  wire [4:0] regAddr;
  wire [15:0] regWdata;
  wire regWrite, configAccessEn, rmiiRef;
  wire [15:0] dec;
  assign dec[12] = 1'b0;
  integer err_count = 0, n_tests = 0, cyc = 0, i;
  phycfg_host host (.*);
  phycfg_setup_reg dut (.*, .strapRole(r[0]), .strapSelfGov(r[1]), .strapHostIf(r[3:2]), .linkUp(r[4]),
    .frameReceivingFlag(r[5]), .symbolError(r[6]), .carrierSense(r[7]), .wakePadIn(r[8]), .modeSleep(r[9]),
    .modeSleepReq(r[10]), .modeStandby(r[11]), .roleMaster(dec[15]), .selfGoverningOperation(dec[14]),
    .cableLong(dec[13]), .txAmplitude(dec[11:10]), .hostIfMode(dec[9:8]), .rmiiRefClkUsed(rmiiRef),
    .driveReduced(dec[7]), .partnerDozeHandshake(dec[6]), .indicatorSourceSelect(dec[5:4]),
    .indicatorPinEnable(dec[3]), .wakeRatiometric(dec[2]), .selfPowerDown(dec[1]),
    .lowPowerSymbolDozeEntry(dec[0]));
  always #2 mclk = ~mclk;
  always @(posedge mclk)
    if (++cyc == 2000)
    begin
      err_count++;
      complete_run;
    end
  function [15:0] pads(input [15:0] g, input [11:0] v);
    pads = {14'h0000, g[3] & v[4 + g[5:4]], v[8] & ~g[3] & |v[11:9]};
  endfunction
  task chk(input string n, input [15:0] e, s);
    n_tests++;
    if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
    if (s !== e) err_count++;
  endtask
  task complete_run;
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    r = $urandom(32'hc98185c4);
    host.rd(5'h12);
    repeat (15) @(negedge mclk);
    arst_n = 1;
    @(negedge mclk) x = 16'h0811 | {r[0], r[1], 4'h0, r[3:2], 8'h00};
    #1 chk("reset", x, regRdata);
    for (i = 0; i < 60; i++)
    begin
      a = i < 2 || $urandom % 4 ? 5'h12 : 5'h13;
      d = i < 2 ? {16{i[0]}} : $urandom;
      if (i >= 2) d[12] = x[12];
      en = i < 2 || $urandom % 3;
      host.wr(a, d, en);
      if (en && a == 5'h12) x = d;
      r = $urandom;
      host.rd(5'h12);
      #1 chk("setup", x, regRdata);
      chk("decode", x & 16'hefff, dec);
      chk("rmii", {15'h0000, x[9:8] == 2'h1}, {15'h0000, rmiiRef});
      @(negedge mclk) chk("pads", pads(x, r), {14'h0000, indicatorOut, localWake});
    end
    host.rd(5'h13);
    #1 chk("unmapped", 16'h0000, regRdata);
    complete_run;
  end
endmodule // test_phy_primary_config_reg
